// ---- design/baud_gen.v ----
// baud generator: down counter at half the system clock, reloaded from the baud value
`timescale 1ns/1ps
`include "sync_serial_consts.vh"
module baud_gen (
	input  wire        clk_in,     // system clock
	input  wire        rst_in,     // synchronous reset
	input  wire        run_in,     // channel enabled
	input  wire [15:0] reload_in,  // baud reload value
	output wire        tick_out,   // one-cycle pulse on underflow
	output wire [15:0] count_out   // current count
);

	reg        half_q;
	reg [15:0] cnt_q;

	// tick when the count is spent on a half-rate step
	assign tick_out  = run_in & half_q & (cnt_q == 16'h0000);
	assign count_out = cnt_q;

	// ----------------------------------------
	// counter, held at the reload value while stopped
	// ----------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			half_q <= 1'b0;
			cnt_q  <= `BAUD_RESET;
		end else if (!run_in) begin
			half_q <= 1'b0;
			cnt_q  <= reload_in;
		end else begin
			half_q <= ~half_q;
			if (half_q) begin
				if (cnt_q == 16'h0000) begin
					cnt_q <= reload_in;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end

endmodule

// ---- design/pin_sync.v ----
// three-stage synchroniser for pins, a change counts once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 3
) (
	input  wire             clk_in,    // system clock
	input  wire             rst_in,    // synchronous reset
	input  wire [WIDTH-1:0] pin_in,    // raw pin levels
	output wire [WIDTH-1:0] level_out  // filtered levels
);

	// ----------------------------------------
	// one chain per pin
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			// first stage is read only by the second
			always @(posedge clk_in) begin
				if (rst_in) begin
					s1_q  <= 1'b1;
					s2_q  <= 1'b1;
					s3_q  <= 1'b1;
					lvl_q <= 1'b1;
				end else begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign level_out[i] = lvl_q;
		end
	endgenerate

endmodule

// ---- design/sync_serial_channel.v ----
// synchronous serial channel: apb registers, master/slave transfer engine, pin drive
`timescale 1ns/1ps
`include "sync_serial_consts.vh"
module sync_serial_channel (
	input  wire        ref_clk_in,                      // system clock, 200 MHz
	input  wire        rst_in,                          // synchronous reset, active high
	input  wire [7:0]  paddr_in,                        // apb address
	input  wire        psel_in,                         // apb select
	input  wire        penable_in,                      // apb enable
	input  wire        pwrite_in,                       // apb direction
	input  wire [31:0] pwdata_in,                       // apb write data
	output reg  [31:0] prdata_out,                      // apb read data
	output reg         pready_out,                      // apb ready
	output reg         pslverr_out,                     // apb error on unmapped address
	input  wire        shift_clk_pin_in,                // clock line level
	output reg         shift_clk_pin_out,               // clock line drive
	output reg         shift_clk_pin_oe_out,            // clock line enable
	input  wire        master_out_slave_in_pin_in,      // transmit line level
	output reg         master_out_slave_in_pin_out,     // transmit line drive
	output reg         master_out_slave_in_pin_oe_out,  // transmit line enable
	input  wire        master_in_slave_out_pin_in,      // receive line level
	output reg         master_in_slave_out_pin_out,     // receive line drive
	output reg         master_in_slave_out_pin_oe_out   // receive line enable
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg        channel_enable_bit_q;
	reg        master_select_bit_q;
	reg        msb_first_q;
	reg        phase_q;
	reg        polarity_q;
	reg [3:0]  data_width_field_q;
	reg [15:0] baud_reload_value_q;
	reg [15:0] transmit_buffer_q;
	reg        tx_full_q;
	reg [15:0] receive_buffer_q;
	reg        busy_q;
	reg        tx_irq_flag_q;
	reg        receive_irq_flag_q;
	reg [2:0]  latch_q;
	reg [15:0] shift_q;
	reg        shift_full_q;
	reg [15:0] rx_q;
	reg [5:0]  edge_cnt_q;
	reg        active_q;
	reg        start_pend_q;
	reg        clk_alt_q;
	reg        data_alt_q;
	reg        clk_prev_q;
	reg [31:0] rdata_d;
	reg        hit_d;

	wire [2:0]  pins_s;
	wire        tick;
	wire [15:0] baud_count;

	// ----------------------------------------
	// pin synchronisers and baud generator
	// ----------------------------------------
	pin_sync #(
		.WIDTH (3)
	) u_sync (
		.clk_in    (ref_clk_in),
		.rst_in    (rst_in),
		.pin_in    ({master_in_slave_out_pin_in, master_out_slave_in_pin_in, shift_clk_pin_in}),
		.level_out (pins_s)
	);

	baud_gen u_baud (
		.clk_in    (ref_clk_in),
		.rst_in    (rst_in),
		.run_in    (channel_enable_bit_q),
		.reload_in (baud_reload_value_q),
		.tick_out  (tick),
		.count_out (baud_count)
	);

	// ----------------------------------------
	// transfer decode
	// ----------------------------------------
	wire        clk_s       = pins_s[0];
	wire [4:0]  bits        = {1'b0, data_width_field_q} + 5'h01;
	wire [5:0]  last_edge   = {bits, 1'b0} - 6'h01;
	// slave follows pin edges, master its own ticks
	wire        slave_edge  = channel_enable_bit_q & ~master_select_bit_q & (clk_s != clk_prev_q);
	wire        master_edge = channel_enable_bit_q & master_select_bit_q & active_q & tick;
	wire        any_edge    = slave_edge | master_edge;
	wire        sample      = (edge_cnt_q[0] == phase_q);
	wire        shift_ok    = ~sample & (edge_cnt_q != 6'h00) & (edge_cnt_q != last_edge);
	wire        in_bit      = master_select_bit_q ? pins_s[2] : pins_s[1];
	wire [15:0] rx_next     = msb_first_q ? {rx_q[14:0], in_bit} : {in_bit, rx_q[15:1]};
	wire [15:0] rx_upd      = sample ? rx_next : rx_q;
	wire [16:0] mask_w      = (17'h0_0001 << bits) - 17'h0_0001;
	wire [4:0]  align_sh    = 5'h10 - bits;
	// right-align the word so bit 0 is the lsb
	wire [15:0] rx_aligned  = msb_first_q ? (rx_upd & mask_w[15:0]) : (rx_upd >> align_sh);
	wire [15:0] shifted     = msb_first_q ? {shift_q[14:0], 1'b1} : {1'b1, shift_q[15:1]};
	wire        fb_shift    = msb_first_q ? shift_q[data_width_field_q] : shift_q[0];
	wire        fb_shifted  = msb_first_q ? shifted[data_width_field_q] : shifted[0];
	wire        fb_tx       = msb_first_q ? transmit_buffer_q[data_width_field_q] : transmit_buffer_q[0];
	wire        fb_wdata    = msb_first_q ? pwdata_in[data_width_field_q] : pwdata_in[0];

	// ----------------------------------------
	// apb strobes, one wait state per access
	// ----------------------------------------
	wire wr_en = psel_in & penable_in & pready_out & pwrite_in;
	wire rd_ph = psel_in & penable_in & ~pready_out;

	// read mux and address decode
	always @* begin
		rdata_d = 32'h0000_0000;
		hit_d   = 1'b1;
		case (paddr_in)
			`ADDR_CTRL: begin
				rdata_d[`CTRL_ENABLE]    = channel_enable_bit_q;
				rdata_d[`CTRL_MASTER]    = master_select_bit_q;
				rdata_d[`CTRL_POLARITY]  = polarity_q;
				rdata_d[`CTRL_PHASE]     = phase_q;
				rdata_d[`CTRL_MSB_FIRST] = msb_first_q;
				rdata_d[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO] = channel_enable_bit_q ?
					edge_cnt_q[4:1] : data_width_field_q;
			end
			`ADDR_TX_BUF: rdata_d[15:0] = transmit_buffer_q;
			`ADDR_RX_BUF: rdata_d[15:0] = receive_buffer_q;
			`ADDR_BAUD:   rdata_d[15:0] = channel_enable_bit_q ? baud_count : baud_reload_value_q;
			`ADDR_STATUS: begin
				rdata_d[`STAT_BUSY]    = busy_q;
				rdata_d[`STAT_TX_FLAG] = tx_irq_flag_q;
				rdata_d[`STAT_RX_FLAG] = receive_irq_flag_q;
			end
			`ADDR_LATCH:  rdata_d[2:0] = latch_q;
			default:      hit_d = 1'b0;
		endcase
	end

	// bus answer registers
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else begin
			pready_out  <= rd_ph;
			pslverr_out <= rd_ph & ~hit_d;
			if (rd_ph) begin
				prdata_out <= hit_d ? rdata_d : 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// registers and transfer engine
	// ----------------------------------------
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			channel_enable_bit_q <= 1'b0;
			master_select_bit_q  <= 1'b0;
			msb_first_q          <= 1'b0;
			phase_q              <= 1'b0;
			polarity_q           <= 1'b0;
			data_width_field_q   <= `WIDTH_RESET;
			baud_reload_value_q  <= `BAUD_RESET;
			transmit_buffer_q    <= `WORD_RESET;
			tx_full_q            <= 1'b0;
			receive_buffer_q     <= `WORD_RESET;
			busy_q               <= 1'b0;
			tx_irq_flag_q        <= 1'b0;
			receive_irq_flag_q   <= 1'b0;
			latch_q              <= `LATCH_RESET;
			shift_q              <= `WORD_RESET;
			shift_full_q         <= 1'b0;
			rx_q                 <= `WORD_RESET;
			edge_cnt_q           <= 6'h00;
			active_q             <= 1'b0;
			start_pend_q         <= 1'b0;
			clk_alt_q            <= 1'b1;
			data_alt_q           <= 1'b1;
			clk_prev_q           <= 1'b1;
		end else begin
			clk_prev_q <= clk_s;
			// software writes; status flags clear on write of one
			if (wr_en) begin
				case (paddr_in)
					`ADDR_CTRL: begin
						channel_enable_bit_q <= pwdata_in[`CTRL_ENABLE];
						master_select_bit_q  <= pwdata_in[`CTRL_MASTER];
						if (!channel_enable_bit_q) begin
							polarity_q         <= pwdata_in[`CTRL_POLARITY];
							phase_q            <= pwdata_in[`CTRL_PHASE];
							msb_first_q        <= pwdata_in[`CTRL_MSB_FIRST];
							data_width_field_q <= pwdata_in[`CTRL_WIDTH_HI:`CTRL_WIDTH_LO];
						end
					end
					`ADDR_TX_BUF: begin
						transmit_buffer_q <= pwdata_in[15:0];
						// only an enabled channel copies into the shift register
						if (channel_enable_bit_q) begin
							if (!shift_full_q) begin
								shift_q      <= pwdata_in[15:0];
								shift_full_q <= 1'b1;
								if (master_select_bit_q) begin
									start_pend_q <= 1'b1;
								end else begin
									data_alt_q    <= fb_wdata;
									tx_irq_flag_q <= 1'b1;
								end
							end else begin
								tx_full_q <= 1'b1;
							end
						end
					end
					`ADDR_BAUD: begin
						if (!channel_enable_bit_q) begin
							baud_reload_value_q <= pwdata_in[15:0];
						end
					end
					`ADDR_STATUS: begin
						if (pwdata_in[`STAT_TX_FLAG]) begin
							tx_irq_flag_q <= 1'b0;
						end
						if (pwdata_in[`STAT_RX_FLAG]) begin
							receive_irq_flag_q <= 1'b0;
						end
					end
					`ADDR_LATCH: latch_q <= pwdata_in[2:0];
					default: ;
				endcase
			end
			// a pending word moves in once the shift register frees
			if (channel_enable_bit_q && tx_full_q && !shift_full_q) begin
				shift_q      <= transmit_buffer_q;
				shift_full_q <= 1'b1;
				tx_full_q    <= 1'b0;
				if (master_select_bit_q) begin
					start_pend_q <= 1'b1;
				end else begin
					data_alt_q    <= fb_tx;
					tx_irq_flag_q <= 1'b1;
				end
			end
			// idle master clock sits at the programmed polarity
			if (channel_enable_bit_q && master_select_bit_q && !active_q) begin
				clk_alt_q <= polarity_q;
			end
			// master start on the tick after the copy
			if (channel_enable_bit_q && master_select_bit_q && start_pend_q && tick && !active_q) begin
				start_pend_q  <= 1'b0;
				active_q      <= 1'b1;
				busy_q        <= 1'b1;
				tx_irq_flag_q <= 1'b1;
				data_alt_q    <= fb_shift;
				edge_cnt_q    <= 6'h00;
			end
			// one clock edge of the transfer, both roles
			if (any_edge) begin
				active_q <= 1'b1;
				busy_q   <= 1'b1;
				if (master_select_bit_q) begin
					clk_alt_q <= ~clk_alt_q;
				end
				if (sample) begin
					rx_q <= rx_next;
				end
				if (shift_ok) begin
					shift_q    <= shifted;
					data_alt_q <= fb_shifted;
				end
				if (edge_cnt_q == last_edge) begin
					edge_cnt_q         <= 6'h00;
					active_q           <= 1'b0;
					receive_buffer_q   <= rx_aligned;
					receive_irq_flag_q <= 1'b1;
					if (tx_full_q) begin
						shift_q   <= transmit_buffer_q;
						tx_full_q <= 1'b0;
						if (master_select_bit_q) begin
							start_pend_q <= 1'b1;
						end else begin
							data_alt_q    <= fb_tx;
							tx_irq_flag_q <= 1'b1;
						end
					end else begin
						shift_full_q <= 1'b0;
						busy_q       <= 1'b0;
					end
				end else begin
					edge_cnt_q <= edge_cnt_q + 6'h01;
				end
			end
			// disabled channel: alternate outputs high, engine idle
			if (!channel_enable_bit_q) begin
				clk_alt_q    <= 1'b1;
				data_alt_q   <= 1'b1;
				active_q     <= 1'b0;
				busy_q       <= 1'b0;
				start_pend_q <= 1'b0;
				shift_full_q <= 1'b0;
				edge_cnt_q   <= 6'h00;
			end
		end
	end

	// ----------------------------------------
	// pin drive: alternate line ANDed with latch
	// ----------------------------------------
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			shift_clk_pin_out              <= 1'b0;
			shift_clk_pin_oe_out           <= 1'b0;
			master_out_slave_in_pin_out    <= 1'b0;
			master_out_slave_in_pin_oe_out <= 1'b0;
			master_in_slave_out_pin_out    <= 1'b0;
			master_in_slave_out_pin_oe_out <= 1'b0;
		end else begin
			shift_clk_pin_out              <= clk_alt_q & latch_q[`LATCH_CLK];
			shift_clk_pin_oe_out           <= channel_enable_bit_q & master_select_bit_q;
			master_out_slave_in_pin_out    <= (master_select_bit_q ? data_alt_q : 1'b1) & latch_q[`LATCH_MOSI];
			master_out_slave_in_pin_oe_out <= channel_enable_bit_q & master_select_bit_q;
			master_in_slave_out_pin_out    <= (master_select_bit_q ? 1'b1 : data_alt_q) & latch_q[`LATCH_MISO];
			master_in_slave_out_pin_oe_out <= channel_enable_bit_q & ~master_select_bit_q;
		end
	end

endmodule

// ---- design/sync_serial_consts.vh ----
// constants for the synchronous serial channel: register map, fields, reset values
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_TX_BUF     8'h04
`define ADDR_RX_BUF     8'h08
`define ADDR_BAUD       8'h0C
`define ADDR_STATUS     8'h10
`define ADDR_LATCH      8'h14

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_WIDTH_HI   3
`define CTRL_WIDTH_LO   0
`define CTRL_MSB_FIRST  4
`define CTRL_PHASE      5
`define CTRL_POLARITY   6
`define CTRL_MASTER     14
`define CTRL_ENABLE     15

// ----------------------------------------
// status and latch fields
// ----------------------------------------
`define STAT_BUSY       0
`define STAT_TX_FLAG    1
`define STAT_RX_FLAG    2
`define LATCH_CLK       0
`define LATCH_MOSI      1
`define LATCH_MISO      2

// ----------------------------------------
// reset values
// ----------------------------------------
`define WIDTH_RESET     4'h0
`define BAUD_RESET      16'h0000
`define LATCH_RESET     3'h0
`define WORD_RESET      16'h0000

`endif

// ---- sim/serial_far_slave.sv ----
// behavioural far-side slave: idle low clock, sample on rise, shift on fall, msb first
`timescale 1ns/1ps
module serial_far_slave (
	input  wire       sclk_in,      // clock line
	input  wire       mosi_in,      // transmit line
	input  wire       sel_in,       // slave chosen to answer
	input  wire [7:0] load_in,      // word to send
	input  wire       load_stb_in,  // load strobe, rising edge
	output wire       miso_out,     // receive line drive
	output wire [7:0] word_out      // received word
);
	reg [7:0] sh_q;
	reg       smp_q;

	// load (all ones when not chosen), sample on leading edge, shift on trailing edge
	always @(posedge load_stb_in) sh_q <= sel_in ? load_in : 8'hFF;
	always @(posedge sclk_in) smp_q <= mosi_in;
	always @(negedge sclk_in) sh_q <= {sh_q[6:0], smp_q};

	// unchosen: line not held at our level
	assign miso_out = sel_in ? sh_q[7] : ~sh_q[7];
	assign word_out = sh_q;
endmodule

// ---- sim/sync_serial_channel_asserts.sv ----
// port checker for the synchronous serial channel
`timescale 1ns/1ps
module sync_serial_channel_asserts (
	input wire        ref_clk_in,                      // system clock
	input wire        rst_in,                          // synchronous reset
	input wire [7:0]  paddr_in,                        // apb address
	input wire        psel_in,                         // apb select
	input wire        penable_in,                      // apb enable
	input wire        pwrite_in,                       // apb direction
	input wire [31:0] pwdata_in,                       // apb write data
	input wire [31:0] prdata_out,                      // apb read data
	input wire        pready_out,                      // apb ready
	input wire        pslverr_out,                     // apb error
	input wire        shift_clk_pin_in,                // clock line level
	input wire        shift_clk_pin_out,               // clock line drive
	input wire        shift_clk_pin_oe_out,            // clock line enable
	input wire        master_out_slave_in_pin_in,      // transmit line level
	input wire        master_out_slave_in_pin_out,     // transmit line drive
	input wire        master_out_slave_in_pin_oe_out,  // transmit line enable
	input wire        master_in_slave_out_pin_in,      // receive line level
	input wire        master_in_slave_out_pin_out,     // receive line drive
	input wire        master_in_slave_out_pin_oe_out   // receive line enable
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	// first access cycle, then one wait state and a single ready pulse
	sequence acc_start;
		psel_in && penable_in && !$past(penable_in);
	endsequence
	sequence one_pulse;
		!pready_out ##1 pready_out ##1 !pready_out;
	endsequence
	apb_wait_a: assert property (acc_start |-> one_pulse)
		else $error("ready not in the second access cycle");
	err_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error answer without ready");
	unmapped_err_a: assert property (pready_out |-> (pslverr_out == (paddr_in > 8'h14 || paddr_in[1:0] != 2'h0)))
		else $error("error answer does not match address");
	err_zero_a: assert property (pslverr_out |-> prdata_out == 32'h0000_0000)
		else $error("unmapped read data not zero");
	upper_zero_a: assert property (pready_out && !pwrite_in |-> prdata_out[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	// ----------------------------------------
	// pin roles and clock pacing
	// ----------------------------------------
	role_pins_a: assert property (shift_clk_pin_oe_out |-> master_out_slave_in_pin_oe_out && !master_in_slave_out_pin_oe_out)
		else $error("master drives wrong data pin");
	slave_pins_a: assert property (master_in_slave_out_pin_oe_out |-> !master_out_slave_in_pin_oe_out && !shift_clk_pin_oe_out)
		else $error("slave drives clock or transmit line");
	// a baud tick is never closer than two system clocks
	clk_hold_a: assert property (shift_clk_pin_oe_out && $changed(shift_clk_pin_out) |=> $stable(shift_clk_pin_out))
		else $error("clock line toggles faster than baud tick");
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the synchronous serial channel
`timescale 1ns/1ps
`include "sync_serial_consts.vh"
module tb_top;
	reg         ref_clk_in, rst_in, psel, pen, pwr, tb_clk, tb_mosi, ld, clk_prev, hold, seen_busy;
	reg  [7:0]  paddr, cap, got;
	reg  [31:0] pwdata, rd;
	reg         er;
	wire [31:0] prdata;
	wire        pready, pslverr, clk_o, clk_oe, mo_o, mo_oe, mi_o, mi_oe, far_miso;
	wire [7:0]  far_word;
	integer     error_cnt, checks_done, cyc, edges, e0;

	// wire levels from all drivers
	wire clk_line = clk_oe ? clk_o : tb_clk;
	wire mo_line  = mo_oe ? mo_o : tb_mosi;
	wire mi_line  = mi_oe ? mi_o : far_miso;

	sync_serial_channel u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .shift_clk_pin_in(clk_line), .shift_clk_pin_out(clk_o),
		.shift_clk_pin_oe_out(clk_oe), .master_out_slave_in_pin_in(mo_line), .master_out_slave_in_pin_out(mo_o),
		.master_out_slave_in_pin_oe_out(mo_oe), .master_in_slave_out_pin_in(mi_line),
		.master_in_slave_out_pin_out(mi_o), .master_in_slave_out_pin_oe_out(mi_oe));
	serial_far_slave u_far (.sclk_in(clk_line), .mosi_in(mo_line), .sel_in(clk_oe), .load_in(8'hA5),
		.load_stb_in(ld), .miso_out(far_miso), .word_out(far_word));

	// clock
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	// rising edges on the clock line, transmit bit captured there; hang guard
	always @(posedge ref_clk_in) begin
		clk_prev <= clk_line;
		cyc <= cyc + 1;
		if (clk_line && !clk_prev) begin
			cap <= {cap[6:0], mo_line};
			edges <= edges + 1;
		end
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			results;
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task results;
		begin
			$display("checks %0d errors %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	task chk(input [31:0] g, input [31:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	// one apb transfer, held until ready is sampled high at a rising edge
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk_in);
			psel <= 1'b1;
			pen <= 1'b0;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk_in);
			pen <= 1'b1;
			@(posedge ref_clk_in);
			while (pready !== 1'b1) @(posedge ref_clk_in);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask

	task rchk(input [7:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0000_0000);
			chk(rd, e);
		end
	endtask

	// poll status until the receive flag shows, noting busy on the way
	task wait_rx;
		begin
			rd = 32'h0000_0000;
			seen_busy = 1'b0;
			while (rd[2] !== 1'b1) begin
				apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
				seen_busy = seen_busy | rd[0];
			end
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		begin
			rchk(`ADDR_CTRL, 32'h0000_0000);
			rchk(`ADDR_STATUS, 32'h0000_0000);
			apb(1'b1, 8'h18, 32'h0000_1234);
			chk(er, 1'b1);
			apb(1'b0, 8'h18, 32'h0000_0000);
			chk(er, 1'b1);
			chk(rd, 32'h0000_0000);
			// reload 3: tick every 8 clocks, an 80 ns line clock, well above the input filter lag
			apb(1'b1, `ADDR_BAUD, 32'h0000_0003);
			rchk(`ADDR_BAUD, 32'h0000_0003);
		end
	endtask

	task t_off;
		begin
			apb(1'b1, `ADDR_LATCH, 32'h0000_0007);
			repeat (4) @(negedge ref_clk_in);
			chk({clk_o, mo_o, mi_o, clk_oe, mo_oe, mi_oe}, 6'b111000);
			apb(1'b1, `ADDR_LATCH, 32'h0000_0005);
			repeat (4) @(negedge ref_clk_in);
			chk({clk_o, mo_o, mi_o}, 3'b101);
			apb(1'b1, `ADDR_TX_BUF, 32'h0000_0055);
			repeat (40) @(negedge ref_clk_in);
			chk(edges, 0);
			rchk(`ADDR_STATUS, 32'h0000_0000);
		end
	endtask

	task t_master;
		begin
			apb(1'b1, `ADDR_LATCH, 32'h0000_0000);
			apb(1'b1, `ADDR_CTRL, 32'h0000_C017);
			apb(1'b1, `ADDR_LATCH, 32'h0000_0007);
			repeat (4) @(negedge ref_clk_in);
			chk({clk_o, clk_oe, mo_oe, mi_oe}, 4'b0110);
			hold = mo_o;
			e0 = edges;
			// far slave loads its word now that our clock drives the line
			@(posedge ref_clk_in) ld <= 1'b1;
			repeat (20) @(negedge ref_clk_in);
			chk(mo_o, hold);
			chk(edges - e0, 0);
			apb(1'b1, `ADDR_TX_BUF, 32'h0000_1F3C);
			wait_rx;
			chk(rd[2:0], 3'b110);
			chk(seen_busy, 1'b1);
			chk(edges - e0, 8);
			chk(cap, 8'h3C);
			chk(far_word, 8'h3C);
			apb(1'b0, `ADDR_RX_BUF, 32'h0000_0000);
			chk(rd[7:0], 8'hA5);
			repeat (30) @(negedge ref_clk_in);
			chk({mo_o, clk_o}, 2'b00);
			apb(1'b1, `ADDR_STATUS, 32'h0000_0006);
			rchk(`ADDR_STATUS, 32'h0000_0000);
		end
	endtask

	// bench acts as master: 80 ns clock within the frame only
	task t_slave;
		integer i;
		begin
			apb(1'b1, `ADDR_CTRL, 32'h0000_0000);
			apb(1'b1, `ADDR_CTRL, 32'h0000_8017);
			repeat (4) @(negedge ref_clk_in);
			chk({clk_oe, mo_oe, mi_oe}, 3'b001);
			apb(1'b1, `ADDR_TX_BUF, 32'h0000_0096);
			repeat (8) @(negedge ref_clk_in);
			chk(mi_o, 1'b1);
			// 8 clocks low, 8 high: 80 ns per bit
			for (i = 7; i >= 0; i = i - 1) begin
				@(posedge ref_clk_in) tb_mosi <= (i % 2 == 0) ? 1'b0 : 1'b1;
				repeat (6) @(posedge ref_clk_in);
				@(negedge ref_clk_in) got = {got[6:0], mi_line};
				@(posedge ref_clk_in) tb_clk <= 1'b1;
				repeat (8) @(posedge ref_clk_in);
				tb_clk <= 1'b0;
			end
			wait_rx;
			chk(got, 8'h96);
			apb(1'b0, `ADDR_RX_BUF, 32'h0000_0000);
			chk(rd[7:0], 8'hAA);
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		error_cnt = 0;
		checks_done = 0;
		cyc = 0;
		edges = 0;
		clk_prev = 1'b0;
		rst_in = 1'b1;
		{psel, pen, pwr, tb_clk, tb_mosi, ld} = 6'b000000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_off;
		t_master;
		t_slave;
		results;
	end
endmodule

bind sync_serial_channel sync_serial_channel_asserts u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
	.paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.shift_clk_pin_in(shift_clk_pin_in), .shift_clk_pin_out(shift_clk_pin_out),
	.shift_clk_pin_oe_out(shift_clk_pin_oe_out), .master_out_slave_in_pin_in(master_out_slave_in_pin_in),
	.master_out_slave_in_pin_out(master_out_slave_in_pin_out),
	.master_out_slave_in_pin_oe_out(master_out_slave_in_pin_oe_out),
	.master_in_slave_out_pin_in(master_in_slave_out_pin_in),
	.master_in_slave_out_pin_out(master_in_slave_out_pin_out),
	.master_in_slave_out_pin_oe_out(master_in_slave_out_pin_oe_out));
